// >>> verilog/madc_pkg.sv
// shared constants and types of the monitor converter control block
package madc_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL0 = 10'h041;
    localparam logic [9:0] IDX_CTRL1 = 10'h042;
    localparam logic [9:0] IDX_RESULT = 10'h043;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h050;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h051;

    // primary control fields
    localparam int CTL0_GO_BIT = 7;
    localparam int CTL0_EN_BIT = 6;
    localparam int CTL0_CLK_LSB = 4;
    localparam int CTL0_SRC_LSB = 0;
    // secondary control fields
    localparam int CTL1_DACT_BIT = 7;
    localparam int CTL1_PRELOAD_BIT = 6;
    localparam int CTL1_PEAK_LSB = 0;
    // interrupt status bits
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_PEAK_BIT = 1;
    localparam int IRQ_W = 2;

    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [7:0] PEAK_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

    localparam logic [2:0] SRC_SAMPLER = 3'h7;
    localparam logic [1:0] PEAK_POS = 2'h3;
    localparam logic [1:0] PEAK_NEG = 2'h1;

    // conversion clock rates, derived from the 125 MHz system clock
    localparam int SYS_CLK_HZ = 125_000_000;
    localparam int CONV_HZ_00 = 5_000_000;
    localparam int CONV_HZ_01 = 2_500_000;
    localparam int CONV_HZ_10 = 1_250_000;
    localparam int CONV_HZ_11 = 625_000;
    localparam logic [7:0] DIV_00 = 8'(SYS_CLK_HZ / CONV_HZ_00);
    localparam logic [7:0] DIV_01 = 8'(SYS_CLK_HZ / CONV_HZ_01);
    localparam logic [7:0] DIV_10 = 8'(SYS_CLK_HZ / CONV_HZ_10);
    localparam logic [7:0] DIV_11 = 8'(SYS_CLK_HZ / CONV_HZ_11);

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SAMPLE = 2'h1,
        ST_CONVERT = 2'h3,
        ST_FINISH = 2'h2
    } madc_state_type;
endpackage

// >>> verilog/madc_conv_clk_div.sv
// conversion clock divider with a one-cycle tick per conversion clock period
`timescale 1ns/1ps
`default_nettype none
module madc_conv_clk_div (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_run,
    input wire logic [7:0] i_div,
    output logic o_tick,
    output logic o_conv_clk
);
    logic [7:0] cnt_ff;
    logic tick_ff;
    logic clk_ff;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_ff <= 8'h00;
            tick_ff <= 1'b0;
            clk_ff <= 1'b0;
        end else if (!i_run) begin
            cnt_ff <= 8'h00;
            tick_ff <= 1'b0;
            clk_ff <= 1'b0;
        end else begin
            tick_ff <= (cnt_ff == i_div - 8'h01);
            clk_ff <= (cnt_ff < {1'b0, i_div[7:1]});
            if (cnt_ff >= i_div - 8'h01) begin
                cnt_ff <= 8'h00;
            end else begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end

    assign o_tick = tick_ff;
    assign o_conv_clk = clk_ff;
endmodule
`default_nettype wire

// >>> verilog/madc_ctrl.sv
// monitor converter control: registers, successive approximation, peak hold
//
// Summary of operation
// - go bit starts one conversion, self-clears
// - go reads zero when result ready
// - enable bit powers converter, cleared at reset
// - clock select 11/10/01/00 = 625k/1.25M/2.5M/5M
// - source select routes ground, supply, pins, junctions
// - source 111 takes sampler, sampler triggers conversions
// - test bit loads written byte into DAC
// - preload copies last written byte, self-clears
// - peak mode 11 positive, 01 negative, else off
// - result read returns latest conversion value
// - result write goes to peak or DAC
`timescale 1ns/1ps
`default_nettype none
module madc_ctrl
    import madc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // analog converter side
    input wire logic i_cmp_above,
    input wire logic i_sampler_trig,
    output logic o_adc_power_en,
    output logic [2:0] o_adc_src_sel,
    output logic o_adc_clk,
    output logic o_sample_track,
    output logic [7:0] o_dac_code,
    output logic [7:0] o_peak_hold,
    output logic o_irq
);
    logic [7:0] ctrl0_ff;
    logic [7:0] ctrl1_ff;
    logic [7:0] result_ff;
    logic [7:0] wr_byte_ff;
    logic [7:0] test_byte_ff;
    logic [7:0] peak_ff;
    logic [7:0] trial_ff;
    logic [2:0] bit_ff;
    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic irq_ff;
    madc_state_type state_ff;
    logic [7:0] dac_ff;
    logic track_ff;

    logic wr_pend_ff;
    logic rd_pend_ff;
    logic [9:0] idx_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;

    logic cmp_s1_ff, cmp_s2_ff;
    logic trg_s1_ff, trg_s2_ff, trg_s3_ff;

    logic conv_tick;
    logic [7:0] conv_div;
    logic addr_ok;
    logic wr_now;
    logic stat_rd_now;
    logic go_wr;
    logic start_conv;
    logic conv_done;
    logic [7:0] final_code;
    logic peak_hit;
    logic dac_test;
    logic [7:0] rd_mux;

    assign dac_test = ctrl1_ff[CTL1_DACT_BIT];

    // pins from the analog side are double-synchronised
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cmp_s1_ff <= 1'b0;
            cmp_s2_ff <= 1'b0;
            trg_s1_ff <= 1'b0;
            trg_s2_ff <= 1'b0;
            trg_s3_ff <= 1'b0;
        end else begin
            cmp_s1_ff <= i_cmp_above;
            cmp_s2_ff <= cmp_s1_ff;
            trg_s1_ff <= i_sampler_trig;
            trg_s2_ff <= trg_s1_ff;
            trg_s3_ff <= trg_s2_ff;
        end
    end

    // ---------------- ahb-lite slave ----------------
    assign addr_ok = hsel && htrans[1] && hready;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            idx_ff <= 10'h000;
            hreadyout_ff <= 1'b1;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= addr_ok && hwrite;
            if (addr_ok) begin
                idx_ff <= haddr[11:2];
            end
            // reads take one wait state so a write just before is visible
            if (addr_ok && !hwrite) begin
                rd_pend_ff <= 1'b1;
                hreadyout_ff <= 1'b0;
            end else if (rd_pend_ff) begin
                rd_pend_ff <= 1'b0;
                hreadyout_ff <= 1'b1;
                hrdata_ff <= {24'h00_0000, rd_mux};
            end
        end
    end

    assign wr_now = wr_pend_ff;
    assign stat_rd_now = rd_pend_ff && (idx_ff == IDX_IRQ_STAT);
    assign go_wr = wr_now && (idx_ff == IDX_CTRL0) && hwdata[CTL0_GO_BIT];

    always_comb begin
        rd_mux = 8'h00;
        unique case (idx_ff)
            IDX_CTRL0: rd_mux = {ctrl0_ff[7:4], 1'b0, ctrl0_ff[2:0]};
            IDX_CTRL1: rd_mux = {ctrl1_ff[7:6], 4'h0, ctrl1_ff[1:0]};
            IDX_RESULT: rd_mux = result_ff;
            IDX_IRQ_STAT: rd_mux = {6'h00, irq_stat_ff};
            IDX_IRQ_MASK: rd_mux = {6'h00, irq_mask_ff};
            default: rd_mux = 8'h00;
        endcase
    end

    // ---------------- control registers ----------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl0_ff <= CTRL0_RST;
        end else begin
            if (wr_now && idx_ff == IDX_CTRL0) begin
                ctrl0_ff[CTL0_EN_BIT] <= hwdata[CTL0_EN_BIT];
                ctrl0_ff[5:4] <= hwdata[5:4];
                ctrl0_ff[2:0] <= hwdata[2:0];
                ctrl0_ff[3] <= 1'b0;
            end
            // go is owned by hardware once set; done, disable or a test-mode abort
            // clear it, otherwise an aborted run would leave go stuck high forever
            if (start_conv) begin
                ctrl0_ff[CTL0_GO_BIT] <= 1'b1;
            end else if (conv_done || !ctrl0_ff[CTL0_EN_BIT] || dac_test) begin
                ctrl0_ff[CTL0_GO_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl1_ff <= CTRL1_RST;
        end else if (wr_now && idx_ff == IDX_CTRL1) begin
            ctrl1_ff <= {hwdata[7:6], 4'h0, hwdata[1:0]};
        end else if (ctrl1_ff[CTL1_PRELOAD_BIT]) begin
            ctrl1_ff[CTL1_PRELOAD_BIT] <= 1'b0;
        end
    end

    // byte written to the result address: kept for preload, routed by mode
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_byte_ff <= RESULT_RST;
            test_byte_ff <= RESULT_RST;
        end else if (wr_now && idx_ff == IDX_RESULT) begin
            wr_byte_ff <= hwdata[7:0];
            if (dac_test) begin
                test_byte_ff <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_mask_ff <= IRQ_MASK_RST;
        end else if (wr_now && idx_ff == IDX_IRQ_MASK) begin
            irq_mask_ff <= hwdata[IRQ_W-1:0];
        end
    end

    // ---------------- conversion clock ----------------
    always_comb begin
        unique case (ctrl0_ff[5:4])
            2'h3: conv_div = DIV_11;
            2'h2: conv_div = DIV_10;
            2'h1: conv_div = DIV_01;
            2'h0: conv_div = DIV_00;
        endcase
    end

    madc_conv_clk_div i_madc_conv_clk_div (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_run(ctrl0_ff[CTL0_EN_BIT]),
        .i_div(conv_div),
        .o_tick(conv_tick),
        .o_conv_clk(o_adc_clk)
    );

    // ---------------- successive approximation ----------------
    // sampler trigger only counts when the sampler is the selected source
    assign start_conv = (state_ff == ST_IDLE) && ctrl0_ff[CTL0_EN_BIT] && !dac_test
        && !ctrl0_ff[CTL0_GO_BIT]
        && (go_wr || (ctrl0_ff[2:0] == SRC_SAMPLER && trg_s2_ff && !trg_s3_ff));
    assign conv_done = (state_ff == ST_FINISH);
    assign final_code = cmp_s2_ff ? trial_ff : (trial_ff & ~(8'h01 << bit_ff));

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= ST_IDLE;
            trial_ff <= 8'h00;
            bit_ff <= 3'h7;
            track_ff <= 1'b0;
        end else if (!ctrl0_ff[CTL0_EN_BIT] || dac_test) begin
            state_ff <= ST_IDLE;
            trial_ff <= 8'h00;
            track_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (start_conv) begin
                        state_ff <= ST_SAMPLE;
                        track_ff <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (conv_tick) begin
                        state_ff <= ST_CONVERT;
                        track_ff <= 1'b0;
                        bit_ff <= 3'h7;
                        trial_ff <= 8'h80;
                    end
                end
                ST_CONVERT: begin
                    // comparator is judged one full conversion clock after the dac moved
                    if (conv_tick) begin
                        trial_ff <= final_code;
                        if (bit_ff == 3'h0) begin
                            state_ff <= ST_FINISH;
                        end else begin
                            bit_ff <= bit_ff - 3'h1;
                            trial_ff <= final_code | (8'h01 << (bit_ff - 3'h1));
                        end
                    end
                end
                ST_FINISH: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            result_ff <= RESULT_RST;
        end else if (conv_done) begin
            result_ff <= trial_ff;
        end
    end

    // ---------------- peak detector ----------------
    assign peak_hit = conv_done
        && ((ctrl1_ff[1:0] == PEAK_POS && trial_ff > peak_ff)
        || (ctrl1_ff[1:0] == PEAK_NEG && trial_ff < peak_ff));

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            peak_ff <= PEAK_RST;
        end else if (ctrl1_ff[CTL1_PRELOAD_BIT]) begin
            peak_ff <= wr_byte_ff;
        end else if (wr_now && idx_ff == IDX_RESULT && ctrl1_ff[1]) begin
            peak_ff <= hwdata[7:0];
        end else if (peak_hit) begin
            peak_ff <= trial_ff;
        end
    end

    // ---------------- interrupts ----------------
    // a read clears status, but an event in that same cycle still sets it
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_stat_ff <= 2'h0;
        end else begin
            irq_stat_ff[IRQ_DONE_BIT] <= conv_done
                || (irq_stat_ff[IRQ_DONE_BIT] && !stat_rd_now);
            irq_stat_ff[IRQ_PEAK_BIT] <= peak_hit
                || (irq_stat_ff[IRQ_PEAK_BIT] && !stat_rd_now);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // dac carries the test byte in test mode, else the trial code
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dac_ff <= 8'h00;
        end else begin
            dac_ff <= dac_test ? test_byte_ff : trial_ff;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;
    assign o_adc_power_en = ctrl0_ff[CTL0_EN_BIT];
    assign o_adc_src_sel = ctrl0_ff[2:0];
    assign o_sample_track = track_ff;
    assign o_dac_code = dac_ff;
    assign o_peak_hold = peak_ff;
    assign o_irq = irq_ff;
endmodule
`default_nettype wire

// >>> dv/madc_ctrl_asserts.sv
// assertion checker for the monitor converter control block
`timescale 1ns/1ps
`default_nettype none
module madc_ctrl_asserts
    import madc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic o_adc_power_en,
    input wire logic [2:0] o_adc_src_sel,
    input wire logic o_adc_clk,
    input wire logic [7:0] o_dac_code,
    input wire logic [7:0] o_peak_hold,
    input wire logic o_irq
);
    logic tk;
    logic dw_ff;
    logic [9:0] di_ff;
    logic [7:0] lr_ff;
    logic [1:0] c1_ff;
    logic [1:0] mk_ff;
    logic wr0;
    logic wr1;
    logic wrr;
    assign tk = hsel & htrans[1] & hready;
    assign wr0 = dw_ff && di_ff == IDX_CTRL0;
    assign wr1 = dw_ff && di_ff == IDX_CTRL1;
    assign wrr = dw_ff && di_ff == IDX_RESULT;
    // shadow of what software wrote, so targets of result writes can be predicted
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dw_ff <= 1'b0;
            di_ff <= 10'h000;
            lr_ff <= 8'h00;
            c1_ff <= 2'h0;
            mk_ff <= 2'h0;
        end else begin
            if (hready) begin
                dw_ff <= tk & hwrite;
                di_ff <= haddr[11:2];
            end
            if (wrr) lr_ff <= hwdata[7:0];
            if (wr1) c1_ff <= {hwdata[7], hwdata[1]};
            if (dw_ff && di_ff == IDX_IRQ_MASK) mk_ff <= hwdata[1:0];
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    property p_okay; hresp == 1'b0; endproperty
    property p_rd_wait; tk && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    property p_wr_nowait; tk && hwrite |=> hreadyout; endproperty
    property p_rd_upper; $rose(hreadyout) |-> hrdata[31:8] == 24'h000000; endproperty
    property p_ctrl0;
        wr0 |=> o_adc_power_en == $past(hwdata[6]) && o_adc_src_sel == $past(hwdata[2:0]);
    endproperty
    property p_clk_off; !o_adc_power_en [*3] |-> !o_adc_clk; endproperty
    property p_preload; wr1 && hwdata[6] |-> ##[1:3] o_peak_hold == lr_ff; endproperty
    property p_res_peak; wrr && c1_ff == 2'h1 |-> ##[1:3] o_peak_hold == lr_ff; endproperty
    property p_res_dac; wrr && c1_ff[1] |-> ##[1:3] o_dac_code == lr_ff; endproperty
    property p_irq_mask; mk_ff == 2'h0 [*2] |-> !o_irq; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    a_ctrl0: assert property (p_ctrl0) else $error("enable or source not applied");
    a_clk_off: assert property (p_clk_off) else $error("clock while disabled");
    a_preload: assert property (p_preload) else $error("preload not copied");
    a_res_peak: assert property (p_res_peak) else $error("peak not loaded");
    a_res_dac: assert property (p_res_dac) else $error("test byte not loaded");
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    c_rd: cover property (tk && !hwrite);
    c_preload: cover property (wr1 && hwdata[6]);
    c_irq: cover property (o_irq);
endmodule
bind madc_ctrl madc_ctrl_asserts i_madc_ctrl_asserts (.*);
`default_nettype wire

// >>> dv/monitor_adc_control_bench.sv
// self-checking bench for the monitor converter control block
`timescale 1ns/1ps
`default_nettype none
module monitor_adc_control_bench
    import madc_pkg::*;
;
    localparam int HZ[4] = '{5_000_000, 2_500_000, 1_250_000, 625_000};
    logic i_sys_clk, i_nrst, hsel, hwrite, i_cmp_above, i_sampler_trig;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, o_adc_src_sel;
    logic [31:0] hwdata, hrdata, d;
    logic hreadyout, hresp, o_adc_power_en, o_adc_clk, o_sample_track, o_irq;
    logic [7:0] o_dac_code, o_peak_hold, vin;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    madc_ctrl i_madc_ctrl (
        .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .i_cmp_above(i_cmp_above), .i_sampler_trig(i_sampler_trig),
        .o_adc_power_en(o_adc_power_en), .o_adc_src_sel(o_adc_src_sel),
        .o_adc_clk(o_adc_clk), .o_sample_track(o_sample_track), .o_dac_code(o_dac_code),
        .o_peak_hold(o_peak_hold), .o_irq(o_irq)
    );
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    // ideal comparator around the analog level vin
    always @(posedge i_sys_clk) i_cmp_above <= (vin >= o_dac_code);
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [9:0] idx, input logic [7:0] v);
        hsel <= 1'b1;
        haddr <= {idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, v};
        do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
    endtask
    task automatic bus_rd(input logic [9:0] idx, output logic [31:0] v);
        hsel <= 1'b1;
        haddr <= {idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= 1'b0;
        do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask
    task automatic rc(input logic [9:0] idx, input logic [7:0] exp);
        logic [31:0] v;
        bus_rd(idx, v);
        chk(v, {24'h000000, exp});
    endtask
    // full conversion; optionally times one conversion clock period
    task automatic conv(input logic [1:0] sel, input logic [7:0] v, input logic tm);
        int n;
        logic [31:0] r;
        vin = v;
        bus_wr(IDX_CTRL0, {2'h1, sel, 4'h0});
        bus_wr(IDX_CTRL0, {2'h3, sel, 4'h0});
        // track goes high at the go write's data edge, so look one edge later
        @(posedge i_sys_clk);
        chk(32'(o_sample_track), 32'h1);
        if (tm) begin
            n = 0;
            while (o_adc_clk !== 1'b0) @(posedge i_sys_clk);
            while (o_adc_clk !== 1'b1) @(posedge i_sys_clk);
            while (o_adc_clk !== 1'b0) begin @(posedge i_sys_clk); n++; end
            while (o_adc_clk !== 1'b1) begin @(posedge i_sys_clk); n++; end
            chk(32'(n), 32'(SYS_CLK_HZ / HZ[sel]));
        end
        bus_rd(IDX_CTRL0, r);
        chk(r & 32'h80, 32'h80);
        do bus_rd(IDX_CTRL0, r); while (r[7] !== 1'b0);
        rc(IDX_RESULT, v);
        chk(32'(o_sample_track), 32'h0);
    endtask
    initial begin
        i_nrst = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        i_sampler_trig = 1'b0;
        i_cmp_above = 1'b0;
        vin = 8'h00;
        repeat (3) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        @(posedge i_sys_clk);
        rc(IDX_CTRL0, 8'h00);
        rc(IDX_CTRL1, 8'h00);
        rc(IDX_IRQ_MASK, 8'h00);
        bus_wr(10'h060, 8'hFF);
        rc(10'h060, 8'h00);
        // enable stays off here so the go write below must be ignored
        for (int s = 0; s < 8; s++) begin
            bus_wr(IDX_CTRL0, 8'(8'h08 | ((s & 3) << 4) | s));
            rc(IDX_CTRL0, 8'(((s & 3) << 4) | s));
            chk(32'(o_adc_src_sel), 32'(s));
        end
        bus_wr(IDX_CTRL0, 8'h80);
        rc(IDX_CTRL0, 8'h00);
        bus_wr(IDX_IRQ_MASK, 8'h01);
        for (int s = 0; s < 4; s++) begin
            conv(2'(s), 8'(8'h17 + s * 8'h3B), 1'b1);
            chk(32'(o_irq), 32'h1);
            rc(IDX_IRQ_STAT, 8'h01);
            repeat (2) @(posedge i_sys_clk);
            chk(32'(o_irq), 32'h0);
        end
        bus_wr(IDX_RESULT, 8'h5A);
        bus_wr(IDX_CTRL1, 8'h40);
        rc(IDX_CTRL1, 8'h00);
        chk(32'(o_peak_hold), 32'h5A);
        bus_wr(IDX_CTRL1, 8'h3E);
        rc(IDX_CTRL1, 8'h02);
        bus_wr(IDX_RESULT, 8'h33);
        repeat (2) @(posedge i_sys_clk);
        chk(32'(o_peak_hold), 32'h33);
        bus_wr(IDX_IRQ_MASK, 8'h00);
        bus_wr(IDX_CTRL1, 8'h03);
        conv(2'h0, 8'h80, 1'b0);
        conv(2'h0, 8'h10, 1'b0);
        chk(32'(o_peak_hold), 32'h80);
        bus_wr(IDX_CTRL1, 8'h01);
        conv(2'h0, 8'h10, 1'b0);
        conv(2'h0, 8'h40, 1'b0);
        chk(32'(o_peak_hold), 32'h10);
        bus_wr(IDX_CTRL1, 8'h02);
        conv(2'h0, 8'h05, 1'b0);
        chk(32'(o_peak_hold), 32'h10);
        chk(32'(o_irq), 32'h0);
        rc(IDX_IRQ_STAT, 8'h03);
        // start a run, then abort it by test mode: go must not stay stuck
        bus_wr(IDX_CTRL0, 8'hC0);
        bus_wr(IDX_CTRL1, 8'h80);
        bus_wr(IDX_RESULT, 8'hA5);
        repeat (2) @(posedge i_sys_clk);
        chk(32'(o_dac_code), 32'hA5);
        bus_wr(IDX_CTRL0, 8'hC0);
        rc(IDX_CTRL0, 8'h40);
        bus_wr(IDX_CTRL1, 8'h00);
        // sampler source: conversion started by the trigger, not by software
        vin = 8'h66;
        bus_wr(IDX_CTRL0, 8'h47);
        i_sampler_trig <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        i_sampler_trig <= 1'b0;
        d = 32'h0;
        for (int k = 0; k < 300 && d !== 32'h66; k++) bus_rd(IDX_RESULT, d);
        chk(d, 32'h66);
        wrap_up();
    end
endmodule
`default_nettype wire
